// ### tb/swt_clk_src_model.sv
// Model of the slow count clocks that reach the timer from outside.
`timescale 1ns/1ps
module swt_clk_src_model
#(
  parameter int SUB_HALF_NS = 20,  // Subsystem clock half period.
  parameter int LS_HALF_NS = 64    // Low-speed clock half period.
)
(
  // Free-running clocks, unrelated in phase to the system clock.
  output logic subsystem_clock,
  output logic low_speed_internal_clock
);
  initial
  begin
    subsystem_clock = 1'b0;
    low_speed_internal_clock = 1'b0;
  end

  // Both run free; only channel 1 of a unit may count them.
  always #(SUB_HALF_NS) subsystem_clock = ~subsystem_clock;
  always #(LS_HALF_NS) low_speed_internal_clock = ~low_speed_internal_clock;
endmodule // swt_clk_src_model

// ### tb/swt_timer_checker.sv
// Assertion checker bound to the ports of the square-wave timer top.
`timescale 1ns/1ps
module swt_timer_checker
  import swt_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  // Register port.
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [DATA_W-1:0] rdata,
  // Alternative count clocks, outputs and interrupt.
  input wire logic subsystem_clock,
  input wire logic low_speed_internal_clock,
  input wire logic [NUM_CH-1:0] channel_wave_output,
  input wire logic irq
);
  // --------------------
  // Shadow copies of what software writes.
  // --------------------
  logic [1:0] en_reg;     // Unit clock enables.
  logic [7:0] dflt_reg;   // Default output levels.
  logic [7:0] mask_reg;   // Interrupt mask.
  logic wr_ok;            // A write that the block takes.
  logic start_w;          // A taken write to the start triggers.
  logic mask_w;           // A taken write to the mask.
  logic [7:0] unit_mask;  // Channels whose unit is enabled.

  assign wr_ok = wr_en && clk_en;
  assign start_w = wr_ok && addr == OFF_START;
  assign mask_w = wr_ok && addr == OFF_MASK;
  assign unit_mask = {{4{en_reg[1]}}, {4{en_reg[0]}}};

  // The shadows land on the same edge as the block's own registers.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      en_reg <= PER_EN_RST;
      dflt_reg <= DEFLVL_RST;
      mask_reg <= MASK_RST;
    end
    else if (wr_ok)
    begin
      if (addr == OFF_PER_EN)
        en_reg <= wdata[1:0];
      if (addr == OFF_DEFLVL)
        dflt_reg <= wdata[7:0];
      if (addr == OFF_MASK)
        mask_reg <= wdata[7:0];
    end
  end

  // --------------------
  // Sequences and assertions.
  // --------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // A start trigger write, and a stop of every channel.
  sequence s_start_write;
    start_w;
  endsequence
  sequence s_stop_all;
    wr_ok && addr == OFF_STOP && wdata[7:0] == 8'hff;
  endsequence

  // Read data stand only in the cycle after the read.
  a_rdata_idle: assert property (
    !rd_en && clk_en |=> rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");

  a_enable_read: assert property (
    rd_en && clk_en && addr == OFF_PER_EN |=> rdata == {30'h0, en_reg})
    else $error("unit enable readback wrong");

  // A unit without its clock enable must not move its outputs.
  a_unit_freeze: assert property (
    (!en_reg[0] |=> $stable(channel_wave_output[3:0])) and
    (!en_reg[1] |=> $stable(channel_wave_output[7:4])))
    else $error("output moved in a disabled unit");

  a_start_level: assert property (
    s_start_write |-> ##2 (((channel_wave_output ^ dflt_reg) &
      $past(wdata[7:0], 2) & unit_mask) == 8'h00))
    else $error("started output not at default level");

  // Once stopped, outputs hold.
  a_stop_hold: assert property (
    s_stop_all |-> ##3 $stable(channel_wave_output)[*6])
    else $error("output moved after stop of all channels");

  a_irq_cause: assert property (
    $rose(irq) |-> ($past(channel_wave_output, 2) !=
      $past(channel_wave_output, 3)) || $past(start_w, 4) ||
      $past(mask_w, 2))
    else $error("interrupt rose without a cause");

  a_mask_zero: assert property (
    mask_reg == 8'h00 && $past(mask_reg) == 8'h00 && $past(clk_en)
      |-> !irq)
    else $error("interrupt high with everything masked");

  // Reset clears the outputs; this one must run during reset.
  a_reset_quiet: assert property (disable iff (1'b0)
    srst && clk_en |=> irq == 1'b0 && channel_wave_output == 8'h00 &&
      rdata == 32'h0000_0000)
    else $error("outputs not cleared by reset");
endmodule // swt_timer_checker

bind swt_timer swt_timer_checker u_checker (
  .clk(clk), .srst(srst), .clk_en(clk_en), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .subsystem_clock(subsystem_clock),
  .low_speed_internal_clock(low_speed_internal_clock),
  .channel_wave_output(channel_wave_output), .irq(irq)
);

// ### tb/swt_timer_tb.sv
// Self-checking testbench of the square-wave timer block.
`timescale 1ns/1ps
module swt_timer_tb
  import swt_pkg::*;
;
  // --------------------
  // Stimulus, observed signals and bookkeeping.
  // --------------------
  logic clk;
  logic srst;
  logic clk_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [DATA_W-1:0] rdata;
  logic sub_clk;
  logic ls_clk;
  logic [NUM_CH-1:0] wave;
  logic irq;
  int err_count;
  int samples_checked;
  logic [31:0] last;  // Data of the latest read.
  logic [15:0] rl [NUM_CH];  // Reload value per channel.
  logic [3:0] dv [NUM_CH];   // Divide exponent per channel.

  swt_timer u_dut (.clk(clk), .srst(srst), .clk_en(clk_en), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .subsystem_clock(sub_clk), .low_speed_internal_clock(ls_clk),
    .channel_wave_output(wave), .irq(irq));
  swt_clk_src_model u_clk_src (.subsystem_clock(sub_clk),
    .low_speed_internal_clock(ls_clk));

  // The 250 MHz system clock.
  always #2 clk = ~clk;

  // --------------------
  // Bus cycles, comparison and closing.
  // --------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One write cycle; the next call waits an edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data are taken just after the edge that follows the strobe.
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    last = rdata;
  endtask

  task automatic chk_rd(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
    rd(a);
    chk(what, exp, last);
  endtask

  // Cycles between two inversions of one output, bounded.
  task automatic half_period(input int n, output int cyc);
    logic w;
    for (int p = 0; p < 2; p++)
    begin
      w = wave[n];
      cyc = 0;
      while (wave[n] === w && cyc < 2000)
      begin
        @(posedge clk);
        #1;
        cyc++;
      end
    end
    if (cyc >= 2000)
    begin
      err_count++;
      $display("mismatch half_period expected toggle seen timeout");
      complete_run();
    end
  endtask

  function automatic logic [31:0] mode_word(input logic sel,
      input swt_src_t src, input logic [3:0] k);
    return {23'h0, sel, 2'h0, src, k};
  endfunction

  // A half period lasts reload plus one count ticks of two to k clocks.
  function automatic int exp_half(input logic [15:0] r, input logic [3:0] k);
    return (int'(r) + 1) << k;
  endfunction

  // --------------------
  // Main sequence.
  // --------------------
  initial
  begin
    int m;
    int i;
    logic [7:0] dl;
    clk = 1'b0;
    srst = 1'b1;
    clk_en = 1'b1;
    addr = '0;
    wdata = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    err_count = 0;
    samples_checked = 0;
    m = $urandom(14);
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    // Reset values, a hole in the map, and a disabled unit.
    chk_rd("per_en", OFF_PER_EN, 32'h0);
    chk_rd("unmapped", 8'hfc, 32'h0);
    wr(8'h40, 32'h5);
    wr(OFF_START, 32'hff);
    chk_rd("running_off", OFF_START, 32'h0);
    wr(8'h60, 32'h1234);
    chk_rd("counter_ro", 8'h60, {16'h0, CNT_RST});
    // Random setup; channel 0 is the shortest case.
    wr(OFF_PER_EN, 32'h3);
    dl = 8'($urandom_range(255, 0));
    wr(OFF_DEFLVL, {24'h0, dl});
    for (int n = 0; n < NUM_CH; n++)
    begin
      rl[n] = (n == 0) ? 16'h0 : 16'($urandom_range(6, 0));
      dv[n] = (n == 0) ? 4'h0 : 4'($urandom_range(4, 0));
      wr(8'(8'h40 + 4 * n), {16'h0, rl[n]});
      wr(8'(8'h20 + 4 * n), mode_word(1'b0,
        (n == 0) ? SRC_SUBSYSTEM : SRC_PRESCALED, dv[n]));
    end
    wr(OFF_START, 32'hff);
    @(posedge clk);
    #1;
    chk("wave_default", {24'h0, dl}, {24'h0, wave});
    chk_rd("running", OFF_START, 32'hff);
    wr(OFF_START, 32'h0);
    chk_rd("start_zero", OFF_START, 32'hff);
    for (int n = 0; n < NUM_CH; n++)
    begin
      half_period(n, m);
      chk("half_period", exp_half(rl[n], dv[n]), m);
    end
    chk_rd("status_all", OFF_STATUS, 32'hff);
    // Stop holds the count; status clears by writing ones.
    wr(OFF_STOP, 32'hff);
    chk_rd("running_stop", OFF_START, 32'h0);
    for (int n = 0; n < NUM_CH; n++)
    begin
      rd(8'(8'h60 + 4 * n));
      chk("cnt_range", 32'h1, {31'h0, (last <= rl[n])});
      chk_rd("cnt_hold", 8'(8'h60 + 4 * n), last);
    end
    wr(OFF_STATUS, 32'hff);
    chk_rd("status_clr", OFF_STATUS, 32'h0);
    // Without the clock enable nothing moves.
    wr(OFF_START, 32'h1);
    @(posedge clk);
    clk_en <= 1'b0;
    #1;
    dl = wave;
    repeat (12) @(posedge clk);
    chk("freeze", {24'h0, dl}, {24'h0, wave});
    clk_en <= 1'b1;
    wr(OFF_STOP, 32'h1);
    // Period interrupt, its mask and its clearing.
    wr(OFF_STATUS, 32'hff);
    wr(OFF_MASK, 32'h1);
    wr(OFF_START, 32'h1);
    i = 0;
    while (irq !== 1'b1 && i < 50)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    chk("irq_raised", 32'h1, {31'h0, irq});
    if (irq !== 1'b1)
      complete_run();
    wr(OFF_STOP, 32'h1);
    wr(OFF_MASK, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    chk("irq_masked", 32'h0, {31'h0, irq});
    chk_rd("status_sticky", OFF_STATUS, 32'h1);
    wr(OFF_STATUS, 32'h1);
    chk_rd("status_w1c", OFF_STATUS, 32'h0);
    // Start event only where selected; long reload keeps periods away.
    for (int n = 1; n < 3; n++)
    begin
      wr(8'(8'h40 + 4 * n), 32'hffff);
      wr(8'(8'h20 + 4 * n), mode_word(n == 1, SRC_PRESCALED, 4'h4));
    end
    wr(OFF_START, 32'h6);
    repeat (6) @(posedge clk);
    chk_rd("start_event", OFF_STATUS, 32'h2);
    wr(OFF_STOP, 32'hff);
    repeat (10) @(posedge clk);
    // Channel 1 of each unit counts the slow clocks of the far side.
    wr(8'h44, 32'h1);
    wr(8'h24, mode_word(1'b0, SRC_SUBSYSTEM, 4'h0));
    wr(8'h54, 32'h0);
    wr(8'h34, mode_word(1'b0, SRC_LOW_SPEED, 4'h0));
    wr(OFF_START, 32'h22);
    for (int j = 0; j < 2; j++)
    begin
      half_period(j * 4 + 1, m);
      chk("alt_clock", 32'h1, {31'h0, (m - (j ? 32 : 20)) inside {[-2:2]}});
    end
    wr(OFF_STOP, 32'hff);
    repeat (10) @(posedge clk);
    complete_run();
  end
endmodule // swt_timer_tb

// ### verilog/swt_channel.sv
// One square-wave channel: reload counter, output and events.
`timescale 1ns/1ps
module swt_channel
  import swt_pkg::*;
(
  // Clock, reset and enables.
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic unit_en,
  // Count clock tick and software triggers.
  input wire logic count_tick,
  input wire logic start_pulse,
  input wire logic stop_pulse,
  // Configuration.
  input wire logic start_irq_sel,
  input wire logic default_level,
  input wire logic [CNT_W-1:0] reload_data,
  // State and events.
  output logic [CNT_W-1:0] counter_reg,
  output logic running_reg,
  output logic wave_reg,
  output logic period_evt_reg,
  output logic start_evt_reg
);

  // Set by a start; the next count clock loads instead of counting.
  logic load_pending_reg;

  // Run control: a stop write halts, a start write (re)starts.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      running_reg <= 1'b0;
      load_pending_reg <= 1'b0;
      start_evt_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      start_evt_reg <= start_pulse & start_irq_sel & unit_en;
      if (!unit_en)
        running_reg <= running_reg;
      else if (stop_pulse)
        running_reg <= 1'b0;
      else if (start_pulse)
      begin
        running_reg <= 1'b1;
        load_pending_reg <= 1'b1;
      end
      else if (running_reg && count_tick)
        load_pending_reg <= 1'b0;
    end
  end

  // Counter, output level and period event on each count clock.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      counter_reg <= CNT_RST;
      wave_reg <= 1'b0;
      period_evt_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      period_evt_reg <= 1'b0;
      if (unit_en && start_pulse && !stop_pulse)
        wave_reg <= default_level;
      else if (unit_en && running_reg && !stop_pulse && count_tick)
      begin
        if (load_pending_reg)
          counter_reg <= reload_data;
        else if (counter_reg == CNT_ZERO)
        begin
          counter_reg <= reload_data;
          wave_reg <= ~wave_reg;
          period_evt_reg <= 1'b1;
        end
        else
          counter_reg <= counter_reg - 1'b1;
      end
    end
  end

endmodule // swt_channel

// ### verilog/swt_pkg.sv
// Package with constants and types of the square-wave timer block.
package swt_pkg;

  // --------------------
  // Organisation of the timer.
  // --------------------
  localparam int NUM_UNITS = 2;       // Timer units 0 and 1.
  localparam int CH_PER_UNIT = 4;     // Channels 0 to 3 in each unit.
  localparam int NUM_CH = 8;          // All channels of both units.
  localparam int CNT_W = 16;          // Counter and reload width.
  localparam int PRESCALE_MAX = 15;   // Deepest divide is two to this.
  localparam int ADDR_W = 8;          // Register port address width.
  localparam int DATA_W = 32;         // Register port data width.

  // --------------------
  // Register offsets.
  // --------------------
  localparam logic [7:0] OFF_PER_EN = 8'h00;  // Unit clock enables.
  localparam logic [7:0] OFF_START = 8'h04;   // Start triggers, running.
  localparam logic [7:0] OFF_STOP = 8'h08;    // Stop triggers.
  localparam logic [7:0] OFF_STATUS = 8'h0c;  // Sticky interrupt status.
  localparam logic [7:0] OFF_MASK = 8'h10;    // Interrupt mask.
  localparam logic [7:0] OFF_DEFLVL = 8'h14;  // Output default levels.
  localparam logic [2:0] REGION_MODE = 3'h1;  // Mode regs at 0x20.
  localparam logic [2:0] REGION_DATA = 3'h2;  // Reload data at 0x40.
  localparam logic [2:0] REGION_CNT = 3'h3;   // Counters at 0x60.

  // --------------------
  // Values after reset.
  // --------------------
  localparam logic [1:0] PER_EN_RST = 2'h0;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] DEFLVL_RST = 8'h00;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  // Count clock source of a channel.
  typedef enum logic [1:0] {
    SRC_PRESCALED,
    SRC_SUBSYSTEM,
    SRC_LOW_SPEED,
    SRC_SPARE
  } swt_src_t;

  // Channel mode register layout: bit 8, bits 5:4, bits 3:0.
  typedef struct packed {
    logic start_irq_sel;   // Interrupt also when counting starts.
    logic [1:0] pad;       // Reads as zero.
    swt_src_t src;         // Count clock source.
    logic [3:0] div_sel;   // Prescaler exponent, 0 to 15.
  } swt_mode_t;

  localparam swt_mode_t MODE_RST = '{1'b0, 2'h0, SRC_PRESCALED, 4'h0};

endpackage : swt_pkg

// ### verilog/swt_prescaler.sv
// Power-of-two prescaler for one timer unit.
`timescale 1ns/1ps
module swt_prescaler
  import swt_pkg::*;
(
  // Clock, reset and enables.
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic unit_en,
  // One tick per divided period, bit k for divide by two to k.
  output logic [PRESCALE_MAX:0] tick_reg
);

  // Free running divider, held at zero while the unit is gated.
  logic [PRESCALE_MAX-1:0] div_reg;
  logic [PRESCALE_MAX:0] tick_next;

  // The undivided tap fires on every clock.
  assign tick_next[0] = 1'b1;

  // Tap k fires when the low k bits of the divider are all ones.
  genvar k;
  generate
    for (k = 1; k <= PRESCALE_MAX; k++)
    begin : g_tap
      assign tick_next[k] = &div_reg[k-1:0];
    end
  endgenerate

  // Divider and tick flops; no ticks reach the unit without its enable.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      div_reg <= '0;
      tick_reg <= '0;
    end
    else if (clk_en)
    begin
      if (unit_en)
      begin
        div_reg <= div_reg + 1'b1;
        tick_reg <= tick_next;
      end
      else
      begin
        div_reg <= '0;
        tick_reg <= '0;
      end
    end
  end

endmodule // swt_prescaler

// ### verilog/swt_timer.sv
// Top of the square-wave timer: registers, clocks and eight channels.
//
// Functional notes
// - Unit runs only with its enable bit set.
// - Count clock is system clock over two-to-k.
// - Subsystem, low-speed clocks only for channel 1.
// - Counter decrements, reloads after reaching zero.
// - Output inverts on count after zero.
// - Start trigger bit one begins counting.
// - Stop trigger halts; start zero does not.
// - Interrupt with reload and output inversion.
// - Optional interrupt when counting starts.
// - Counter readable, set only via reload data.
// - Output level before first inversion selectable.
// - Two units of four independent channels.

`timescale 1ns/1ps
module swt_timer
  import swt_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,

  // Register port.
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rdata,

  // Alternative count clocks from outside this clock domain.
  input wire logic subsystem_clock,
  input wire logic low_speed_internal_clock,

  // Square-wave outputs, one per channel, unit 1 in the upper half.
  output logic [NUM_CH-1:0] channel_wave_output,

  // Level interrupt.
  output logic irq
);

  // --------------------
  // Register state.
  // --------------------
  logic [NUM_UNITS-1:0] peripheral_enable_reg; // Unit clock enables.
  logic [NUM_CH-1:0] status_reg;     // Sticky interrupt flags.
  logic [NUM_CH-1:0] mask_reg;       // One enables the flag onto irq.
  logic [NUM_CH-1:0] deflvl_reg;     // Output level after a start.

  logic [NUM_CH-1:0] start_pulse_reg; // One-cycle start triggers.
  logic [NUM_CH-1:0] stop_pulse_reg;  // One-cycle stop triggers.
  logic [DATA_W-1:0] rdata_reg;      // Read data, one cycle late.
  logic irq_reg;                     // Registered interrupt.

  // Per-channel configuration, one word each.
  swt_mode_t channel_mode_reg [NUM_CH];
  logic [CNT_W-1:0] channel_reload_data [NUM_CH];

  // --------------------
  // Channel state seen by the register port.
  // --------------------
  logic [CNT_W-1:0] channel_counter [NUM_CH];
  logic [NUM_CH-1:0] running;
  logic [NUM_CH-1:0] wave;
  logic [NUM_CH-1:0] period_evt;
  logic [NUM_CH-1:0] start_evt;

  logic [NUM_CH-1:0] chan_unit_en;   // Enable of each channel's unit.

  // Write decode helpers.
  logic [2:0] region;                // Which register array is hit.
  logic [2:0] ch_idx;                // Channel index within an array.
  logic [NUM_CH-1:0] unit_mask;      // Channels of enabled units.
  logic [NUM_CH-1:0] status_clr;     // Write-one-to-clear bits.

  // Array entries sit four bytes apart, region first.
  assign region = addr[7:5];
  assign ch_idx = addr[4:2];

  // --------------------
  // Unit enables and prescalers.
  // --------------------
  // Bit k of a unit ticks every two to k clocks.
  logic [PRESCALE_MAX:0] unit_tick [NUM_UNITS];

  // Unit enable register; triggers and channel writes of a disabled
  // unit are ignored, so a gated unit really stands still.
  always_ff @(posedge clk)
  begin
    if (srst)
      peripheral_enable_reg <= PER_EN_RST;
    else if (clk_en && wr_en && addr == OFF_PER_EN)
      peripheral_enable_reg <= wdata[NUM_UNITS-1:0];
  end

  // Each channel inherits the enable of its own unit.
  assign chan_unit_en = {{CH_PER_UNIT{peripheral_enable_reg[1]}},
                         {CH_PER_UNIT{peripheral_enable_reg[0]}}};
  assign unit_mask = chan_unit_en;

  genvar u;
  generate
    for (u = 0; u < NUM_UNITS; u++)
    begin : g_unit
      // One shared prescaler per unit keeps channels phase aligned.
      swt_prescaler u_prescaler (
        .clk(clk),
        .srst(srst),
        .clk_en(clk_en),
        .unit_en(peripheral_enable_reg[u]),
        .tick_reg(unit_tick[u])
      );
    end
  endgenerate

  // --------------------
  // Synchronisers for the outside count clocks.
  // --------------------
  // Bit 0 is the first flop; only bit 1 reads it. Edges are taken
  // between bits 1 and 2. These clocks must run well below clk/2,
  // otherwise edges are lost in the crossing.
  logic [2:0] sub_sync_reg;
  logic [2:0] lsi_sync_reg;
  logic sub_tick;
  logic lsi_tick;

  // Two-stage synchronisers plus one edge-history stage.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sub_sync_reg <= 3'h0;
      lsi_sync_reg <= 3'h0;
    end
    else if (clk_en)
    begin
      sub_sync_reg <= {sub_sync_reg[1:0], subsystem_clock};
      lsi_sync_reg <= {lsi_sync_reg[1:0], low_speed_internal_clock};
    end
  end

  // Rising edges of the synchronised clocks act as count ticks.
  assign sub_tick = sub_sync_reg[1] & ~sub_sync_reg[2];
  assign lsi_tick = lsi_sync_reg[1] & ~lsi_sync_reg[2];

  // --------------------
  // Triggers.
  // --------------------
  // Start and stop writes become one-cycle pulses per channel; a zero
  // bit leaves its channel alone, so a zero start never stops one.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      start_pulse_reg <= '0;
      stop_pulse_reg <= '0;
    end
    else if (clk_en)
    begin
      start_pulse_reg <= '0;
      stop_pulse_reg <= '0;
      if (wr_en && addr == OFF_START)
        start_pulse_reg <= wdata[NUM_CH-1:0] & unit_mask;
      if (wr_en && addr == OFF_STOP)
        stop_pulse_reg <= wdata[NUM_CH-1:0] & unit_mask;
    end
  end

  // --------------------
  // Mask and default level registers.
  // --------------------
  // Mask and default output levels are plain read/write bits.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mask_reg <= MASK_RST;
      deflvl_reg <= DEFLVL_RST;
    end
    else if (clk_en && wr_en)
    begin
      if (addr == OFF_MASK)
        mask_reg <= wdata[NUM_CH-1:0];
      if (addr == OFF_DEFLVL)
        deflvl_reg <= wdata[NUM_CH-1:0];
    end
  end

  // --------------------
  // Channels.
  // --------------------
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++)
    begin : g_ch
      logic count_tick; // Selected count clock of this channel.
      logic hit;        // Register write addresses this channel.

      // A gated unit drops writes to its channels.
      assign hit = wr_en && ch_idx == 3'(c) &&
                   chan_unit_en[c];

      // Mode and reload data of this channel. The counter itself has
      // no write path; software sets it only through the reload data.
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          channel_mode_reg[c] <= MODE_RST;
          channel_reload_data[c] <= DATA_RST;
        end
        else if (clk_en && hit)
        begin
          if (region == REGION_MODE)
          begin
            channel_mode_reg[c].start_irq_sel <= wdata[8];
            channel_mode_reg[c].pad <= 2'h0;
            channel_mode_reg[c].src <= swt_src_t'(wdata[5:4]);
            channel_mode_reg[c].div_sel <= wdata[3:0];
          end
          if (region == REGION_DATA)
            channel_reload_data[c] <= wdata[CNT_W-1:0];
        end
      end

      // Count clock choice. Only channel 1 of a unit may take the
      // subsystem or low-speed clock; elsewhere the source field is
      // ignored and the prescaler is used.
      if (c % CH_PER_UNIT == 1)
      begin : g_alt_src
        always_comb
        begin
          case (channel_mode_reg[c].src)
            SRC_SUBSYSTEM:
              count_tick = sub_tick & chan_unit_en[c];
            SRC_LOW_SPEED:
              count_tick = lsi_tick & chan_unit_en[c];
            default:
              count_tick =
                unit_tick[c / CH_PER_UNIT][channel_mode_reg[c].div_sel];
          endcase
        end
      end
      else
      begin : g_pre_src
        assign count_tick =
          unit_tick[c / CH_PER_UNIT][channel_mode_reg[c].div_sel];
      end

      // One independent channel with its own state.
      swt_channel u_channel (
        .clk(clk),
        .srst(srst),
        .clk_en(clk_en),
        .unit_en(chan_unit_en[c]),
        .count_tick(count_tick),
        .start_pulse(start_pulse_reg[c]),
        .stop_pulse(stop_pulse_reg[c]),
        .start_irq_sel(channel_mode_reg[c].start_irq_sel),
        .default_level(deflvl_reg[c]),
        .reload_data(channel_reload_data[c]),
        .counter_reg(channel_counter[c]),
        .running_reg(running[c]),
        .wave_reg(wave[c]),
        .period_evt_reg(period_evt[c]),
        .start_evt_reg(start_evt[c])
      );
    end
  endgenerate

  // The wave flops sit in the channels, so the pins are registered.
  assign channel_wave_output = wave;

  // --------------------
  // Interrupts.
  // --------------------
  assign status_clr = (wr_en && addr == OFF_STATUS) ?
                      wdata[NUM_CH-1:0] : '0;

  // Sticky flags; an event in the clearing cycle survives the clear.
  always_ff @(posedge clk)
  begin
    if (srst)
      status_reg <= '0;
    else if (clk_en)
      status_reg <= (status_reg & ~status_clr) |
                    period_evt | start_evt;
  end

  // The interrupt line is registered so it comes from a flop.
  always_ff @(posedge clk)
  begin
    if (srst)
      irq_reg <= 1'b0;
    else if (clk_en)
      irq_reg <= |(status_reg & mask_reg);
  end

  assign irq = irq_reg;

  // --------------------
  // Read port.
  // --------------------
  logic [DATA_W-1:0] rd_mux;

  // Read multiplexer; unmapped addresses read as zero.
  always_comb
  begin
    rd_mux = '0;
    case (addr)
      OFF_PER_EN:
        rd_mux[NUM_UNITS-1:0] = peripheral_enable_reg;
      OFF_START:
        rd_mux[NUM_CH-1:0] = running;
      OFF_STATUS:
        rd_mux[NUM_CH-1:0] = status_reg;
      OFF_MASK:
        rd_mux[NUM_CH-1:0] = mask_reg;
      OFF_DEFLVL:
        rd_mux[NUM_CH-1:0] = deflvl_reg;
      default:
      begin
        if (region == REGION_MODE && addr[1:0] == 2'h0)
          rd_mux[8:0] = channel_mode_reg[ch_idx];
        else if (region == REGION_DATA && addr[1:0] == 2'h0)
          rd_mux[CNT_W-1:0] = channel_reload_data[ch_idx];
        else if (region == REGION_CNT && addr[1:0] == 2'h0)
          rd_mux[CNT_W-1:0] = channel_counter[ch_idx];
      end
    endcase
  end

  // Read data stands in the cycle after the strobe only.
  always_ff @(posedge clk)
  begin
    if (srst)
      rdata_reg <= '0;
    else if (clk_en)
      rdata_reg <= rd_en ? rd_mux : '0;
  end

  assign rdata = rdata_reg;

endmodule // swt_timer
